// ===== flow_through_sync_burst_sram.sv
`timescale 1ns/1ps
module flow_through_sync_burst_sram #(
  parameter int          ADDR_W = sram_pkg::ADDR_W_DEF,
  parameter int          LANES  = sram_pkg::LANES_DEF,
  parameter logic [31:0] IDCODE = sram_pkg::IDCODE_DEF
) (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              reset_n_i,
  // Command pins
  input  wire logic [ADDR_W-1:0]                 addr_i,
  input  wire logic                              chip_sel_1_n_i,
  input  wire logic                              chip_sel_2_i,
  input  wire logic                              chip_sel_3_n_i,
  input  wire logic                              write_n_i,
  input  wire logic [LANES-1:0]                  lane_write_sel_n_i,
  input  wire logic                              advance_or_load_i,
  input  wire logic                              clk_qualify_n_i,
  // Control pins
  input  wire logic                              output_enable_n_i,
  input  wire logic                              sleep_request_i,
  input  wire logic                              burst_order_strap_i,
  // Data bus
  input  wire logic [LANES*sram_pkg::LANE_W-1:0] dq_i,
  output logic      [LANES*sram_pkg::LANE_W-1:0] dq_o,
  output logic                                   dq_oe_n_o,
  // Scan port
  input  wire logic                              tck_i,
  input  wire logic                              tms_i,
  input  wire logic                              tdi_i,
  output logic                                   tdo_o,
  output logic                                   tdo_oe_n_o,
  // Status
  output logic                                   power_down_o
);

  localparam int W  = LANES * sram_pkg::LANE_W;
  localparam int BW = sram_pkg::BURST_W;

  // Storage array
  logic [W-1:0] mem [0:(1<<ADDR_W)-1];

  // Sleep pin synchroniser and strap capture
  logic                sleep_meta;
  logic                sleep_sync;
  logic                strap_meta;
  logic                strap_sync;
  logic                strap_taken;
  logic                order_interleaved;

  // Captured access state
  logic                op_active;
  logic                op_write;
  logic [ADDR_W-1:BW]  op_base;
  logic [BW-1:0]       op_start;
  logic [BW-1:0]       op_count;
  logic [LANES-1:0]    op_lanes_n;

  logic                next_active;
  logic                next_write;
  logic [ADDR_W-1:BW]  next_base;
  logic [BW-1:0]       next_start;
  logic [BW-1:0]       next_count;
  logic [LANES-1:0]    next_lanes_n;

  // Decode of the pins as seen at this edge
  wire                 run        = ~clk_qualify_n_i;
  wire                 selected   = ~chip_sel_1_n_i & chip_sel_2_i & ~chip_sel_3_n_i;
  wire                 do_advance = advance_or_load_i;
  wire [BW-1:0]        burst_start_bits = addr_i[BW-1:0];
  wire                 order_pick = (strap_sync == sram_pkg::STRAP_INTERLEAVED);

  // Word address within the four-word group
  wire [BW-1:0]        linear_low = op_start + op_count;
  wire [BW-1:0]        inter_low  = op_start ^ op_count;
  wire [BW-1:0]        burst_low  = order_interleaved ? inter_low : linear_low;
  wire [ADDR_W-1:0]    cur_addr   = {op_base, burst_low};

  // Array read and lane merge for writes
  wire [W-1:0]         rd_word = mem[cur_addr];
  wire [W-1:0]         wr_word;
  wire                 do_write = run & op_active & op_write & ~sleep_sync;
  wire                 do_read  = op_active & ~op_write & ~sleep_sync;

  // Lanes whose select is high write back what the array already holds
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1)
    begin : g_lane
      localparam int LO = lane * sram_pkg::LANE_W;
      assign wr_word[LO +: sram_pkg::LANE_W] = op_lanes_n[lane]
                                             ? rd_word[LO +: sram_pkg::LANE_W]
                                             : dq_i[LO +: sram_pkg::LANE_W];
    end
  endgenerate

  // Next access: load a new command or step the burst counter
  // Lane selects are taken on every beat, so each word of a burst has its own mask
  always_comb
  begin
    next_active  = op_active;
    next_write   = op_write;
    next_base    = op_base;
    next_start   = op_start;
    next_count   = op_count;
    next_lanes_n = op_lanes_n;
    if (sleep_sync)
    begin
      next_active = 1'b0;
    end
    else if (do_advance)
    begin
      next_count   = op_count + sram_pkg::COUNT_STEP;
      next_lanes_n = lane_write_sel_n_i;
    end
    else
    begin
      next_active  = selected;
      next_write   = ~write_n_i;
      next_base    = addr_i[ADDR_W-1:BW];
      next_start   = burst_start_bits;
      next_count   = sram_pkg::COUNT_RESET;
      next_lanes_n = lane_write_sel_n_i;
    end
  end

  // Sleep request is asynchronous to the clock
  always_ff @(posedge clk_i)
  begin
    sleep_meta <= sleep_request_i;
    sleep_sync <= sleep_meta;
  end

  // Strap is an off-domain pin too, so it passes two flops before use
  always_ff @(posedge clk_i)
  begin
    strap_meta <= burst_order_strap_i;
    strap_sync <= strap_meta;
  end

  // Burst order is caught once after reset release; the strap must stay put
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      strap_taken       <= 1'b0;
      order_interleaved <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap_taken       <= 1'b1;
      order_interleaved <= order_pick;
    end
  end

  // Input registers, held while the clock is not qualified
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      op_active  <= 1'b0;
      op_write   <= 1'b0;
      op_base    <= '0;
      op_start   <= sram_pkg::COUNT_RESET;
      op_count   <= sram_pkg::COUNT_RESET;
      op_lanes_n <= '1;
    end
    else if (run)
    begin
      op_active  <= next_active;
      op_write   <= next_write;
      op_base    <= next_base;
      op_start   <= next_start;
      op_count   <= next_count;
      op_lanes_n <= next_lanes_n;
    end
  end

  // Write data is taken on the edge closing its data cycle
  // A stalled edge keeps the write pending until the next qualified edge
  always_ff @(posedge clk_i)
  begin
    if (do_write)
    begin
      mem[cur_addr] <= wr_word;
    end
  end

  // Reduced power while asleep or deselected
  // Sleep acts even on stalled edges; deselect only on qualified ones
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      power_down_o <= 1'b1;
    else if (sleep_sync)
      power_down_o <= 1'b1;
    else if (run)
      power_down_o <= ~next_active;
  end

  // Flow-through read path: array output goes straight to the pins
  assign dq_o = rd_word;

  // Drivers off in write data cycles and whenever output enable is high
  // Output enable bypasses the clock so a released bus is freed at once
  assign dq_oe_n_o = ~(do_read & ~output_enable_n_i);

  // Scan pins are slow and sampled on the system clock
  scan_tap #(
    .IDCODE (IDCODE)
  ) u_tap (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .tck_i      (tck_i),
    .tms_i      (tms_i),
    .tdi_i      (tdi_i),
    .tdo_o      (tdo_o),
    .tdo_oe_n_o (tdo_oe_n_o)
  );

endmodule : flow_through_sync_burst_sram

// ===== sram_pkg.sv
// Notes on behaviour
// - All synchronous pins are captured on the rising clock edge before use.
// - Clock qualify high freezes the access registers and read data; sleep sync and power down still update.
// - A new read or write is accepted on every qualified clock, no idle cycles.
// - One data word moves on every qualified cycle of consecutive accesses.
// - A write updates only the byte lanes whose select is low.
// - Writes finish inside one clock, no extra recovery cycles needed.
// - Data drivers are off during the data cycle of every write.
// - An access starts only when all three chip selects are active.
// - Output enable turns data drivers off at once, without the clock.
// - Bursts step through words in linear or interleaved order.
// - Sleep input or deselect puts the device into reduced power.
// - Read data flows from array to pins in the cycle after capture.
// - Array is 2M x 36 or 1M x 72, split into byte lanes.
// - A boundary-scan test access port follows the standard protocol.
// - The two lowest address bits load the two-bit burst counter.
package sram_pkg;

  // Array shape, narrow variant by default
  localparam int ADDR_W_DEF  = 21;
  localparam int LANES_DEF   = 4;
  localparam int LANE_W      = 9;
  localparam int BURST_W     = 2;

  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] COUNT_STEP  = 2'h1;

  // Strap level that selects each burst order
  localparam logic STRAP_INTERLEAVED = 1'h1;

  // Test access port
  localparam int          IR_W          = 3;
  localparam int          ID_W          = 32;
  localparam logic [2:0]  IR_CAPTURE    = 3'h1;
  localparam logic [2:0]  INSTR_IDCODE  = 3'h1;
  localparam logic [2:0]  INSTR_BYPASS  = 3'h7;
  // Arbitrary identification value; bit 0 is one as the scan standard requires
  localparam logic [31:0] IDCODE_DEF    = 32'h0000_0a51;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_e;

endpackage : sram_pkg

// ===== scan_tap.sv
`timescale 1ns/1ps
module scan_tap #(
  parameter logic [31:0] IDCODE = sram_pkg::IDCODE_DEF
) (
  // System
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Scan pins
  input  wire logic tck_i,
  input  wire logic tms_i,
  input  wire logic tdi_i,
  output logic      tdo_o,
  output logic      tdo_oe_n_o
);

  logic [2:0]                  tck_sync;
  logic [1:0]                  tms_sync;
  logic [1:0]                  tdi_sync;
  sram_pkg::tap_state_e        state;
  sram_pkg::tap_state_e        next_state;
  logic [sram_pkg::IR_W-1:0]   ir;
  logic [sram_pkg::IR_W-1:0]   ir_shift;
  logic [sram_pkg::ID_W-1:0]   dr_shift;
  wire                         tck_rise = tck_sync[1] & ~tck_sync[2];
  wire                         tck_fall = ~tck_sync[1] & tck_sync[2];
  wire                         tms = tms_sync[1];
  wire                         tdi = tdi_sync[1];
  wire                         use_id = (ir == sram_pkg::INSTR_IDCODE);
  wire                         shifting_ir = (state == sram_pkg::TAP_SHIFT_IR);
  wire                         shifting = shifting_ir | (state == sram_pkg::TAP_SHIFT_DR);

  // Standard sixteen-state controller walk
  always_comb
  begin
    case (state)
      sram_pkg::TAP_RESET:    next_state = tms ? sram_pkg::TAP_RESET : sram_pkg::TAP_IDLE;
      sram_pkg::TAP_IDLE:     next_state = tms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
      sram_pkg::TAP_SEL_DR:   next_state = tms ? sram_pkg::TAP_SEL_IR : sram_pkg::TAP_CAP_DR;
      sram_pkg::TAP_CAP_DR:   next_state = tms ? sram_pkg::TAP_EXIT1_DR : sram_pkg::TAP_SHIFT_DR;
      sram_pkg::TAP_SHIFT_DR: next_state = tms ? sram_pkg::TAP_EXIT1_DR : sram_pkg::TAP_SHIFT_DR;
      sram_pkg::TAP_EXIT1_DR: next_state = tms ? sram_pkg::TAP_UPD_DR : sram_pkg::TAP_PAUSE_DR;
      sram_pkg::TAP_PAUSE_DR: next_state = tms ? sram_pkg::TAP_EXIT2_DR : sram_pkg::TAP_PAUSE_DR;
      sram_pkg::TAP_EXIT2_DR: next_state = tms ? sram_pkg::TAP_UPD_DR : sram_pkg::TAP_SHIFT_DR;
      sram_pkg::TAP_UPD_DR:   next_state = tms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
      sram_pkg::TAP_SEL_IR:   next_state = tms ? sram_pkg::TAP_RESET : sram_pkg::TAP_CAP_IR;
      sram_pkg::TAP_CAP_IR:   next_state = tms ? sram_pkg::TAP_EXIT1_IR : sram_pkg::TAP_SHIFT_IR;
      sram_pkg::TAP_SHIFT_IR: next_state = tms ? sram_pkg::TAP_EXIT1_IR : sram_pkg::TAP_SHIFT_IR;
      sram_pkg::TAP_EXIT1_IR: next_state = tms ? sram_pkg::TAP_UPD_IR : sram_pkg::TAP_PAUSE_IR;
      sram_pkg::TAP_PAUSE_IR: next_state = tms ? sram_pkg::TAP_EXIT2_IR : sram_pkg::TAP_PAUSE_IR;
      sram_pkg::TAP_EXIT2_IR: next_state = tms ? sram_pkg::TAP_UPD_IR : sram_pkg::TAP_SHIFT_IR;
      sram_pkg::TAP_UPD_IR:   next_state = tms ? sram_pkg::TAP_SEL_DR : sram_pkg::TAP_IDLE;
      default:                next_state = sram_pkg::TAP_RESET;
    endcase
  end

  // Scan pins are sampled on the system clock
  always_ff @(posedge clk_i)
  begin
    tck_sync <= {tck_sync[1:0], tck_i};
    tms_sync <= {tms_sync[0], tms_i};
    tdi_sync <= {tdi_sync[0], tdi_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state    <= sram_pkg::TAP_RESET;
      ir       <= sram_pkg::INSTR_IDCODE;
      ir_shift <= sram_pkg::IR_CAPTURE;
      dr_shift <= '0;
    end
    else if (tck_rise)
    begin
      state <= next_state;
      case (state)
        sram_pkg::TAP_RESET:    ir <= sram_pkg::INSTR_IDCODE;
        sram_pkg::TAP_CAP_IR:   ir_shift <= sram_pkg::IR_CAPTURE;
        sram_pkg::TAP_SHIFT_IR: ir_shift <= {tdi, ir_shift[sram_pkg::IR_W-1:1]};
        sram_pkg::TAP_UPD_IR:   ir <= ir_shift;
        sram_pkg::TAP_CAP_DR:   dr_shift <= use_id ? IDCODE : '0;
        sram_pkg::TAP_SHIFT_DR:
          if (use_id)
            dr_shift <= {tdi, dr_shift[sram_pkg::ID_W-1:1]};
          else
            dr_shift[0] <= tdi;
        default:                dr_shift <= dr_shift;
      endcase
    end
  end

  // Output changes on the falling scan clock, driven only while shifting
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo_o      <= shifting_ir ? ir_shift[0] : dr_shift[0];
      tdo_oe_n_o <= ~shifting;
    end
  end

endmodule : scan_tap

// ===== sram_checker_sva.sv
`timescale 1ns/1ps
module sram_checker #(
  parameter int LANES = sram_pkg::LANES_DEF
) (
  // Watched pins
  input wire logic                              clk_i,
  input wire logic                              reset_n_i,
  input wire logic                              chip_sel_1_n_i,
  input wire logic                              chip_sel_2_i,
  input wire logic                              chip_sel_3_n_i,
  input wire logic                              write_n_i,
  input wire logic                              advance_or_load_i,
  input wire logic                              clk_qualify_n_i,
  input wire logic                              output_enable_n_i,
  input wire logic                              sleep_request_i,
  input wire logic [LANES*sram_pkg::LANE_W-1:0] dq_o,
  input wire logic                              dq_oe_n_o,
  input wire logic                              power_down_o
);
  wire logic load = !clk_qualify_n_i && !advance_or_load_i;
  wire logic sel  = !chip_sel_1_n_i && chip_sel_2_i && !chip_sel_3_n_i;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_deselect_no_drive: assert property (load && !sel |=> dq_oe_n_o)
    else $error("data driven after a deselected load");
  chk_write_tristate: assert property (load && sel && !write_n_i |=> dq_oe_n_o)
    else $error("data driven in a write data phase");
  chk_read_flow:
    assert property (load && sel && write_n_i && !sleep_request_i && !$past(sleep_request_i)
      && !$past(sleep_request_i, 2) |=> output_enable_n_i || !dq_oe_n_o)
    else $error("read data not driven in the cycle after the load");
  chk_idle_advance:
    assert property (load && !sel ##1 !clk_qualify_n_i && advance_or_load_i |=> dq_oe_n_o)
    else $error("advance while idle started an access");
  chk_oe_async: assert property (output_enable_n_i |-> dq_oe_n_o)
    else $error("data driven while output enable is off");
  chk_stall_hold: assert property (clk_qualify_n_i |=> $stable(dq_o))
    else $error("read data moved on a stalled edge");
  chk_sleep_power: assert property (sleep_request_i [*4] |=> power_down_o)
    else $error("no power down while asleep");
  chk_deselect_power: assert property (load && !sel |=> power_down_o)
    else $error("no power down after deselect");
  chk_awake_access:
    assert property (load && sel && !sleep_request_i && !$past(sleep_request_i)
      && !$past(sleep_request_i, 2) |=> !power_down_o)
    else $error("power down during an access");
endmodule : sram_checker

bind flow_through_sync_burst_sram sram_checker #(.LANES(LANES)) u_sram_checker (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_sel_1_n_i(chip_sel_1_n_i),
  .chip_sel_2_i(chip_sel_2_i), .chip_sel_3_n_i(chip_sel_3_n_i), .write_n_i(write_n_i),
  .advance_or_load_i(advance_or_load_i), .clk_qualify_n_i(clk_qualify_n_i),
  .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
  .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .power_down_o(power_down_o)
);

// ===== ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model #(
  parameter int AW = 8
) (
  // Clock
  input  wire logic     clk_i,
  // Command and write data toward the memory
  output logic [AW-1:0] addr_o,
  output logic          chip_sel_1_n_o,
  output logic          chip_sel_2_o,
  output logic          chip_sel_3_n_o,
  output logic          write_n_o,
  output logic [3:0]    lane_write_sel_n_o,
  output logic          advance_or_load_o,
  output logic          clk_qualify_n_o,
  output logic [35:0]   dq_o
);
  logic        wr_burst = 1'h0;
  logic [35:0] wdata_q  = 36'h0;
  initial
  begin
    addr_o             = {AW{1'h0}};
    chip_sel_1_n_o     = 1'h1;
    chip_sel_2_o       = 1'h0;
    chip_sel_3_n_o     = 1'h1;
    write_n_o          = 1'h1;
    lane_write_sel_n_o = 4'hf;
    advance_or_load_o  = 1'h0;
    clk_qualify_n_o    = 1'h0;
    dq_o               = 36'h0;
  end
  // One command a call, launched after an edge; write data trails it by one taken edge
  task automatic beat(input logic [2:0] c, input logic [2:0] s, input logic [AW-1:0] a,
                      input logic [3:0] ln, input logic [35:0] wd);
    @(posedge clk_i);
    // A stalled edge stretches the data phase, so the bus stays as it is
    if (!clk_qualify_n_o)
    begin
      if (!advance_or_load_o)
        wr_burst = !write_n_o && !chip_sel_1_n_o && chip_sel_2_o && !chip_sel_3_n_o;
      // Released bus shows the inverse of the last word
      dq_o <= wr_burst ? wdata_q : ~dq_o;
    end
    wdata_q = wd;
    clk_qualify_n_o    <= c[2];
    write_n_o          <= c[1];
    advance_or_load_o  <= c[0];
    chip_sel_1_n_o     <= !s[0];
    chip_sel_2_o       <= s[1];
    chip_sel_3_n_o     <= !s[2];
    lane_write_sel_n_o <= ln;
    addr_o             <= a;
  endtask : beat
endmodule : ctrl_model

// ===== flow_through_sync_burst_sram_tb.sv
`timescale 1ns/1ps
module flow_through_sync_burst_sram_tb;
  typedef struct packed {
    logic [2:0]  ctl;
    logic [2:0]  s;
    logic [7:0]  a;
    logic [3:0]  ln;
    logic [35:0] wd;
    logic        e_oe;
    logic [35:0] e_dq;
  } row_s;
  localparam logic [35:0] W0 = 36'h0_0000_00a0;
  localparam logic [35:0] W1 = 36'h1_1111_1111;
  localparam logic [35:0] W2 = 36'h2_2222_2222;
  localparam logic [35:0] W3 = 36'h3_3333_3333;
  // W1 with lanes 0 and 2 overwritten by ones
  localparam logic [35:0] M1 = 36'h1_17fd_11ff;
  // Scan mode levels that walk from test reset into data shifting
  localparam logic [3:0]  TMS_TO_SHIFT = 4'h2;
  localparam row_s IDLE = '{3'h2, 3'h0, 8'h00, 4'hf, 36'h0, 1'h1, 36'h0};
  logic        clk_i             = 1'h0;
  logic        reset_n_i         = 1'h0;
  logic        strap             = 1'h0;
  logic        output_enable_n_i = 1'h0;
  logic        sleep_request_i   = 1'h0;
  logic        oe_nx             = 1'h0;
  logic        slp_nx            = 1'h0;
  logic        tck               = 1'h0;
  logic        tms               = 1'h0;
  logic        tdi               = 1'h0;
  logic        tdo;
  logic        bit_seen;
  logic [7:0]  addr;
  logic        cs1_n, cs2, cs3_n, we_n, adv, cq_n, dq_oe_n, pd, tdo_oe_n;
  logic [3:0]  lanes_n;
  logic [35:0] wdata, rdata;
  int          mismatches = 0;
  int          n_checks   = 0;
  row_s        prev       = IDLE;
  row_s        rows [17]  = '{
    '{3'h0, 3'h7, 8'h10, 4'h0, W0, 1'h1, 36'h0}, '{3'h1, 3'h7, 8'h00, 4'h0, W1, 1'h1, 36'h0},
    '{3'h1, 3'h7, 8'h00, 4'h0, W2, 1'h1, 36'h0}, '{3'h1, 3'h7, 8'h00, 4'h0, W3, 1'h1, 36'h0},
    '{3'h2, 3'h7, 8'h12, 4'hf, 36'h0, 1'h0, W2}, '{3'h3, 3'h7, 8'h00, 4'hf, 36'h0, 1'h0, W3},
    '{3'h3, 3'h7, 8'h00, 4'hf, 36'h0, 1'h0, W0}, '{3'h3, 3'h7, 8'h00, 4'hf, 36'h0, 1'h0, W1},
    '{3'h0, 3'h7, 8'h11, 4'ha, 36'hf_ffff_ffff, 1'h1, 36'h0},
    '{3'h2, 3'h7, 8'h11, 4'hf, 36'h0, 1'h0, M1}, '{3'h2, 3'h6, 8'h10, 4'hf, 36'h0, 1'h1, 36'h0},
    '{3'h2, 3'h5, 8'h10, 4'hf, 36'h0, 1'h1, 36'h0}, '{3'h2, 3'h3, 8'h10, 4'hf, 36'h0, 1'h1, 36'h0},
    '{3'h3, 3'h7, 8'h00, 4'hf, 36'h0, 1'h1, 36'h0}, '{3'h2, 3'h7, 8'h10, 4'hf, 36'h0, 1'h0, W0},
    '{3'h6, 3'h7, 8'h13, 4'hf, 36'h0, 1'h0, W0}, '{3'h3, 3'h7, 8'h00, 4'hf, 36'h0, 1'h0, M1}};
  always #5 clk_i = ~clk_i;
  ctrl_model #(.AW(8)) u_ctrl_model (
    .clk_i(clk_i), .addr_o(addr), .chip_sel_1_n_o(cs1_n), .chip_sel_2_o(cs2),
    .chip_sel_3_n_o(cs3_n), .write_n_o(we_n), .lane_write_sel_n_o(lanes_n),
    .advance_or_load_o(adv), .clk_qualify_n_o(cq_n), .dq_o(wdata)
  );
  flow_through_sync_burst_sram #(.ADDR_W(8), .LANES(4)) u_flow_through_sync_burst_sram (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .chip_sel_1_n_i(cs1_n),
    .chip_sel_2_i(cs2), .chip_sel_3_n_i(cs3_n), .write_n_i(we_n),
    .lane_write_sel_n_i(lanes_n), .advance_or_load_i(adv), .clk_qualify_n_i(cq_n),
    .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
    .burst_order_strap_i(strap), .dq_i(wdata), .dq_o(rdata), .dq_oe_n_o(dq_oe_n),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .power_down_o(pd)
  );
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_bit
  task automatic check_word(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  function automatic row_s rd(input logic [2:0] c, input logic [7:0] a, input logic e_oe,
                              input logic [35:0] e);
    rd = '{c, 3'h7, a, 4'hf, 36'h0, e_oe, e};
  endfunction : rd
  // Launches a row and checks the row that the same edge sampled
  task automatic cyc(input row_s r);
    u_ctrl_model.beat(r.ctl, r.s, r.a, r.ln, r.wd);
    output_enable_n_i <= oe_nx;
    sleep_request_i   <= slp_nx;
    #1;
    check_bit("dq_oe_n_o", prev.e_oe, dq_oe_n);
    if (!prev.e_oe)
      check_word("dq_o", prev.e_dq, rdata);
    prev = r;
  endtask : cyc
  task automatic do_reset(input logic order);
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    strap     <= order;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'h1;
    #1;
    check_bit("power_down_o", 1'h1, pd);
    check_bit("tdo_oe_n_o", 1'h1, tdo_oe_n);
    prev = IDLE;
  endtask : do_reset
  // One slow scan clock period: fall with new pin levels, sample out, then rise
  task automatic scan_step(input logic ms, output logic seen);
    tck <= 1'h0;
    tms <= ms;
    tdi <= ~tdi;
    repeat (4) @(posedge clk_i);
    seen = tdo;
    tck <= 1'h1;
    repeat (4) @(posedge clk_i);
  endtask : scan_step
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  initial
  begin
    #20000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    do_reset(1'h0);
    foreach (rows[i])
      cyc(rows[i]);
    cyc(IDLE);
    $display("table test done");
    slp_nx = 1'h1;
    repeat (4) cyc(IDLE);
    check_bit("power_down_o", 1'h1, pd);
    cyc(rd(3'h2, 8'h10, 1'h1, 36'h0));
    slp_nx = 1'h0;
    repeat (4) cyc(IDLE);
    cyc(rd(3'h2, 8'h10, 1'h0, W0));
    cyc(rd(3'h3, 8'h00, 1'h0, M1));
    check_bit("power_down_o", 1'h0, pd);
    cyc(IDLE);
    $display("sleep test done");
    cyc(rd(3'h2, 8'h12, 1'h0, W2));
    cyc(rd(3'h6, 8'h13, 1'h1, 36'h0));
    oe_nx = 1'h1;
    cyc(rd(3'h6, 8'h13, 1'h0, W2));
    oe_nx = 1'h0;
    cyc(IDLE);
    $display("output enable test done");
    do_reset(1'h1);
    cyc(rd(3'h2, 8'h11, 1'h0, M1));
    cyc(rd(3'h3, 8'h00, 1'h0, W0));
    cyc(rd(3'h3, 8'h00, 1'h0, W3));
    cyc(rd(3'h3, 8'h00, 1'h0, W2));
    cyc(IDLE);
    $display("burst order test done");
    for (int i = 0; i < 4; i++)
      scan_step(TMS_TO_SHIFT[i], bit_seen);
    for (int i = 0; i < sram_pkg::ID_W; i++)
    begin
      scan_step(1'h0, bit_seen);
      check_bit("tdo_o", sram_pkg::IDCODE_DEF[i], bit_seen);
    end
    check_bit("tdo_oe_n_o", 1'h0, tdo_oe_n);
    repeat (2) scan_step(1'h1, bit_seen);
    check_bit("tdo_oe_n_o", 1'h1, tdo_oe_n);
    $display("scan test done");
    wrap_up();
  end
endmodule : flow_through_sync_burst_sram_tb
